// >>> rtl/gic_pkg.sv
// Constants, state codes and response helpers for the two-wire command port.
// Assumes a single 100 MHz system clock; the bench repeats the target addresses in a table of its own.
package gic_pkg;

  // ----------------------------------------------------------------
  // Clocking and bus rate
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FAST_MODE_BPS = 400_000;
  // Shortest legal bus clock period, in system clocks
  localparam int unsigned SCL_MIN_CYC = CLK_HZ / FAST_MODE_BPS;

  // ----------------------------------------------------------------
  // Target addresses (7 bit), chosen by the factory setting
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_DEFAULT = 7'h68;
  localparam logic [6:0] ADDR_ALT1 = 7'h69;
  localparam logic [6:0] ADDR_ALT2 = 7'h58;
  localparam logic [6:0] ADDR_ALT3 = 7'h59;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_RATE = 8'h25;
  localparam logic [7:0] CMD_TEMP = 8'h26;
  localparam logic [7:0] CMD_SELF_TEST = 8'h29;
  localparam logic [7:0] CMD_SRST_FIRST = 8'h35;
  localparam logic [7:0] CMD_SRST_LAST = 8'h39;
  localparam logic [2:0] SRST_LAST_STEP = 3'h4;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
  localparam int unsigned RATE_W = 16;
  localparam int unsigned TEMP_W = 11;
  localparam int unsigned RESP_W = 16;
  localparam int unsigned SELF_TEST_FLAG_POS = 6;

  typedef enum logic [2:0] {
    GIC_IDLE = 3'b000,
    GIC_ADDR = 3'b001,
    GIC_ADDR_ACK = 3'b010,
    GIC_CMD = 3'b011,
    GIC_CMD_ACK = 3'b100,
    GIC_TX = 3'b101,
    GIC_TX_ACK = 3'b110
  } gic_state_t;

  // Number of response bytes a command code produces
  function automatic logic [1:0] gic_resp_len(input logic [7:0] code);
    logic [1:0] len;
    len = 2'h0;
    if (code == CMD_RATE || code == CMD_TEMP) begin
      len = 2'h2;
    end else if (code == CMD_SELF_TEST) begin
      len = 2'h1;
    end
    return len;
  endfunction : gic_resp_len

  function automatic logic [6:0] gic_addr_lookup(input logic [1:0] sel);
    logic [6:0] a;
    a = ADDR_DEFAULT;
    unique case (sel)
      2'h0: a = ADDR_DEFAULT;
      2'h1: a = ADDR_ALT1;
      2'h2: a = ADDR_ALT2;
      2'h3: a = ADDR_ALT3;
    endcase
    return a;
  endfunction : gic_addr_lookup

endpackage : gic_pkg

// >>> rtl/gic_line_if.sv
// Conditioned bus-line events passed from the line sampler to the protocol engine.
// All signals are on the system clock; event signals are one-cycle pulses.
`timescale 1ns/1ps
interface gic_line_if;
  logic scl;
  logic sda;
  logic sel_ok;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport src (output scl, output sda, output sel_ok, output scl_rise, output scl_fall, output start, output stop);
  modport snk (input scl, input sda, input sel_ok, input scl_rise, input scl_fall, input start, input stop);
endinterface : gic_line_if

// >>> rtl/gic_line_sync.sv
// Samples the bus clock, bus data and select pins into the system clock domain
// and derives edge, start and stop pulses. Assumes pins are asynchronous.
`timescale 1ns/1ps
module gic_line_sync (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sel_i,
  gic_line_if.src line
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers; stage one feeds stage two only
  // ----------------------------------------------------------------
  logic [2:0] meta;
  logic [2:0] stable;
  logic [2:0] prev;
  logic [2:0] next_meta;
  logic [2:0] next_stable;
  logic [2:0] next_prev;
  logic next_scl_rise;
  logic next_scl_fall;
  logic next_start;
  logic next_stop;

  // Same latency on both lines keeps start/stop against the clock level honest.
  // At 10 ns sampling a 2.5 us fast-mode bit gives ample margin.
  always_comb begin
    next_meta = {sel_i, sda_i, scl_i};
    next_stable = meta;
    next_prev = stable;
    next_scl_rise = stable[0] & ~prev[0];
    next_scl_fall = ~stable[0] & prev[0];
    // Data falling while the clock is high
    next_start = stable[0] & prev[0] & prev[1] & ~stable[1];
    // Data rising while the clock is high
    next_stop = stable[0] & prev[0] & ~prev[1] & stable[1];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // All three pins idle high, so no false select drop or edge follows reset
      meta <= 3'h7;
      stable <= 3'h7;
      prev <= 3'h7;
      line.scl_rise <= 1'b0;
      line.scl_fall <= 1'b0;
      line.start <= 1'b0;
      line.stop <= 1'b0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
      line.scl_rise <= next_scl_rise;
      line.scl_fall <= next_scl_fall;
      line.start <= next_start;
      line.stop <= next_stop;
    end
  end

  // Levels are delayed one cycle to line up with the event pulses
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line.scl <= 1'b1;
      line.sda <= 1'b1;
      line.sel_ok <= 1'b1;
    end else begin
      line.scl <= prev[0];
      line.sda <= prev[1];
      line.sel_ok <= prev[2];
    end
  end

endmodule : gic_line_sync

// >>> rtl/gic_cmd_port.sv
// Two-wire target for the rate sensor: takes one command code per write frame,
// returns the chosen response in a read frame, and runs the soft reset sequence.
// Assumes sensor data inputs come from logic on the same clock and the address
// select comes from a factory setting that is stable once reset is released.
`timescale 1ns/1ps

// Functional notes
// - Two-wire mode needs select high, input unused
// - Each byte followed by one acknowledge clock
// - Read frame: restart, address, read, response, stop
// - Answer default or factory alternative address
// - Bit after address selects direction
// - Stop returns target to idle
// - Bus rate at most 400 kbit/s
// - Code 25h returns 16-bit signed rate
// - Code 26h returns 11-bit signed temperature
// - Code 29h returns one self-test byte
// - Failure flag high on detected internal failure
// - Reset pulses upon receiving code 39h; code pulses only when 35h to 38h were the four codes before it
// - Reset codes produce no response data
module gic_cmd_port #(
  parameter int unsigned RATE_BITS = gic_pkg::RATE_W,
  parameter int unsigned TEMP_BITS = gic_pkg::TEMP_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic sel_i,
  input wire logic [1:0] addr_sel_i,
  input wire logic [RATE_BITS-1:0] rate_i,
  input wire logic [TEMP_BITS-1:0] temp_i,
  input wire logic self_test_fail_flag_i,
  output logic soft_rst_o,
  output logic [7:0] cmd_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (RATE_BITS != gic_pkg::RESP_W) begin : g_bad_rate
    $error("rate width must fill the 16-bit response");
  end
  if (TEMP_BITS > gic_pkg::RESP_W || TEMP_BITS < 2) begin : g_bad_temp
    $error("temperature width must be 2 to 16 bits");
  end

  // ----------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------
  gic_line_if line ();

  gic_line_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sel_i(sel_i),
    .line(line)
  );

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  gic_pkg::gic_state_t state;
  gic_pkg::gic_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [15:0] tx;
  logic [15:0] next_tx;
  logic [1:0] bytes_left;
  logic [1:0] next_bytes_left;
  logic more;
  logic next_more;
  logic rw;
  logic next_rw;
  logic [2:0] rst_step;
  logic [2:0] next_rst_step;
  logic [6:0] own_addr;
  logic [6:0] next_own_addr;
  logic strap_done;
  logic next_strap_done;
  logic next_sda_oe;
  logic next_soft_rst;
  logic [7:0] next_cmd;
  logic [15:0] resp_word;
  logic addr_hit;

  // Snapshot of the selected measurement, MSB-aligned for one-byte answers
  always_comb begin
    resp_word = 16'h0000;
    unique case (cmd_o)
      gic_pkg::CMD_RATE: resp_word = rate_i[15:0];
      gic_pkg::CMD_TEMP: begin
        // Upper bits stay zero rather than sign-extended
        resp_word[TEMP_BITS-1:0] = temp_i;
      end
      gic_pkg::CMD_SELF_TEST: begin
        resp_word[8 + gic_pkg::SELF_TEST_FLAG_POS] = self_test_fail_flag_i;
      end
      default: resp_word = 16'h0000;
    endcase
  end

  assign addr_hit = (shreg[7:1] == own_addr);

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx = tx;
    next_bytes_left = bytes_left;
    next_more = more;
    next_rw = rw;
    next_rst_step = rst_step;
    next_own_addr = own_addr;
    next_strap_done = 1'b1;
    next_sda_oe = sda_oe_o;
    next_soft_rst = 1'b0;
    next_cmd = cmd_o;
    // Factory address is caught once, just after reset release
    if (!strap_done) begin
      next_own_addr = gic_pkg::gic_addr_lookup(addr_sel_i);
    end
    if (!line.sel_ok) begin
      // Select low means the bus belongs to another mode
      next_state = gic_pkg::GIC_IDLE;
      next_sda_oe = 1'b0;
    end else if (line.start) begin
      next_state = gic_pkg::GIC_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (line.stop) begin
      next_state = gic_pkg::GIC_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        gic_pkg::GIC_IDLE: begin
          next_sda_oe = 1'b0;
        end
        gic_pkg::GIC_ADDR, gic_pkg::GIC_CMD: begin
          if (line.scl_rise) begin
            next_shreg = {shreg[6:0], line.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (line.scl_fall && bit_cnt == gic_pkg::BIT_COUNT_FULL) begin
            next_bit_cnt = 4'h0;
            if (state == gic_pkg::GIC_ADDR) begin
              if (addr_hit) begin
                next_sda_oe = 1'b1;
                next_rw = shreg[0];
                next_state = gic_pkg::GIC_ADDR_ACK;
              end else begin
                next_state = gic_pkg::GIC_IDLE;
              end
            end else begin
              next_sda_oe = 1'b1;
              next_state = gic_pkg::GIC_CMD_ACK;
              next_cmd = shreg;
              // Soft reset sequence tracker
              if (shreg == gic_pkg::CMD_SRST_FIRST + {5'h00, rst_step}) begin
                if (rst_step == gic_pkg::SRST_LAST_STEP) begin
                  next_soft_rst = 1'b1;
                  next_rst_step = 3'h0;
                end else begin
                  next_rst_step = rst_step + 3'h1;
                end
              end else if (shreg == gic_pkg::CMD_SRST_FIRST) begin
                next_rst_step = 3'h1;
              end else begin
                next_rst_step = 3'h0;
              end
            end
          end
        end
        gic_pkg::GIC_ADDR_ACK: begin
          if (line.scl_fall) begin
            if (rw) begin
              next_state = gic_pkg::GIC_TX;
              next_tx = resp_word;
              next_bytes_left = gic_pkg::gic_resp_len(cmd_o);
              // No answer data: leave the line released, master reads ones
              next_sda_oe = (gic_pkg::gic_resp_len(cmd_o) != 2'h0) && !resp_word[15];
            end else begin
              next_state = gic_pkg::GIC_CMD;
              next_sda_oe = 1'b0;
            end
          end
        end
        gic_pkg::GIC_CMD_ACK: begin
          // One code per write frame; further bytes go unacknowledged
          if (line.scl_fall) begin
            next_sda_oe = 1'b0;
            next_state = gic_pkg::GIC_IDLE;
          end
        end
        gic_pkg::GIC_TX: begin
          if (line.scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (line.scl_fall) begin
            if (bit_cnt == gic_pkg::BIT_COUNT_FULL) begin
              next_sda_oe = 1'b0;
              next_state = gic_pkg::GIC_TX_ACK;
              next_more = 1'b0;
            end else begin
              next_tx = {tx[14:0], 1'b0};
              next_sda_oe = (bytes_left != 2'h0) && !tx[14];
            end
          end
        end
        gic_pkg::GIC_TX_ACK: begin
          if (line.scl_rise) begin
            // A NACK ends the answer even if bytes remain
            next_more = !line.sda && (bytes_left > 2'h1);
          end else if (line.scl_fall) begin
            next_bit_cnt = 4'h0;
            if (more) begin
              next_state = gic_pkg::GIC_TX;
              next_bytes_left = bytes_left - 2'h1;
              next_tx = {tx[14:0], 1'b0};
              next_sda_oe = !tx[14];
            end else begin
              next_state = gic_pkg::GIC_IDLE;
              next_sda_oe = 1'b0;
            end
          end
        end
        default: begin
          next_state = gic_pkg::GIC_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
    // Soft reset clears the held command so a later read stays silent
    if (soft_rst_o) begin
      next_cmd = gic_pkg::CMD_NONE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= gic_pkg::GIC_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 16'h0000;
      bytes_left <= 2'h0;
      more <= 1'b0;
      rw <= 1'b0;
      rst_step <= 3'h0;
      own_addr <= gic_pkg::ADDR_DEFAULT;
      strap_done <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
      soft_rst_o <= 1'b0;
      cmd_o <= gic_pkg::CMD_NONE;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx <= next_tx;
      bytes_left <= next_bytes_left;
      more <= next_more;
      rw <= next_rw;
      rst_step <= next_rst_step;
      own_addr <= next_own_addr;
      strap_done <= next_strap_done;
      sda_oe_o <= next_sda_oe;
      // Open-drain: only ever pulls low
      sda_o <= 1'b0;
      soft_rst_o <= next_soft_rst;
      cmd_o <= next_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  logic quiet;
  assign quiet = line.sel_ok && !line.start && !line.stop;

  a_addr_ack_drive: assert property (
    (quiet && state == gic_pkg::GIC_ADDR && line.scl_fall && bit_cnt == 4'h8 && addr_hit)
      |=> (sda_oe_o && state == gic_pkg::GIC_ADDR_ACK))
    else $error("matching address not acknowledged");

  a_addr_foreign: assert property (
    (quiet && state == gic_pkg::GIC_ADDR && line.scl_fall && bit_cnt == 4'h8 && !addr_hit)
      |=> (!sda_oe_o && state == gic_pkg::GIC_IDLE))
    else $error("foreign address answered");

  a_ack_holds: assert property (
    (state == gic_pkg::GIC_ADDR_ACK && sda_oe_o && quiet && !line.scl_fall) |=> sda_oe_o)
    else $error("acknowledge released early");

  a_stop_idle: assert property (
    (line.sel_ok && line.stop && !line.start) |=> (state == gic_pkg::GIC_IDLE && !sda_oe_o))
    else $error("stop did not return to idle");

  a_start_addr: assert property (
    (line.sel_ok && line.start) |=> (state == gic_pkg::GIC_ADDR && bit_cnt == 4'h0 && !sda_oe_o))
    else $error("start did not open address phase");

  a_select_low: assert property (
    !line.sel_ok |=> (state == gic_pkg::GIC_IDLE && !sda_oe_o))
    else $error("bus driven with select low");

  a_write_dir: assert property (
    (quiet && state == gic_pkg::GIC_ADDR_ACK && line.scl_fall && !rw) |=> state == gic_pkg::GIC_CMD)
    else $error("write direction not honoured");

  a_rst_cause: assert property (
    soft_rst_o |-> ($past(rst_step) == 3'h4 && $past(shreg) == gic_pkg::CMD_SRST_LAST) ##1 !soft_rst_o)
    else $error("soft reset without full sequence");

  a_rst_silent: assert property (
    (quiet && state == gic_pkg::GIC_ADDR_ACK && line.scl_fall && rw && gic_pkg::gic_resp_len(cmd_o) == 2'h0)
      |=> !sda_oe_o [*2])
    else $error("data driven for a command with no response");

  a_msb_first: assert property (
    (quiet && state == gic_pkg::GIC_ADDR_ACK && line.scl_fall && rw && gic_pkg::gic_resp_len(cmd_o) != 2'h0)
      |=> (sda_oe_o == !$past(resp_word[15])))
    else $error("first response bit is not the MSB");

  a_nack_ends: assert property (
    (quiet && state == gic_pkg::GIC_TX_ACK && line.scl_rise && line.sda) |=> !more)
    else $error("answer continued after NACK");

  a_oe_scl_low: assert property (
    $rose(sda_oe_o) |-> !line.scl)
    else $error("data line pulled while bus clock high");

endmodule : gic_cmd_port

// >>> sim/gic_bus_master_model.sv
// Behavioural two-wire bus master driving the bus clock and its side of the data line.
// Assumes the bench resolves the open-drain data line with a pull-up and calls tasks at a clock edge.
`timescale 1ns/1ps
module gic_bus_master_model #(
  parameter int unsigned QTR = 4
) (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // ----------------------------------------------------------------
  // Bus phases, one quarter bit each
  // ----------------------------------------------------------------
  // Four phases of QTR clocks give a 160 ns bit, well above fast mode, to keep runs short
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wait_q();
    repeat (QTR) @(posedge clk_sys_i);
  endtask : wait_q

  // Works from idle and, with the clock low, as a repeated start
  task automatic start();
    sda_o <= 1'b1;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    sda_o <= 1'b0;
    wait_q();
    scl_o <= 1'b0;
    wait_q();
  endtask : start

  task automatic stop();
    sda_o <= 1'b0;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    sda_o <= 1'b1;
    wait_q();
    wait_q();
  endtask : stop

  // Data changes only while the clock is low; the line is read halfway through the high phase
  task automatic bit_cyc(input logic b, output logic got);
    sda_o <= b;
    wait_q();
    scl_o <= 1'b1;
    wait_q();
    got = sda_i;
    wait_q();
    scl_o <= 1'b0;
    wait_q();
  endtask : bit_cyc

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(b[i], g);
    end
    bit_cyc(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, g);
      b[i] = g;
    end
    bit_cyc(nack, g);
  endtask : rd_byte

endmodule : gic_bus_master_model

// >>> sim/tb_top.sv
// Self-checking bench for the two-wire command port: write, read, refusal and soft reset frames.
// Assumes the bus master model drives the bus and the bench resolves the open-drain line.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk_sys_i;
  logic rst_n_i;
  logic sel_i;
  logic self_test_fail_flag_i;
  logic [1:0] addr_sel_i;
  logic [15:0] rate_i;
  logic [10:0] temp_i;
  logic sda_o;
  logic sda_oe_o;
  logic soft_rst_o;
  logic [7:0] cmd_o;
  logic scl_line;
  logic mst_sda;
  wire logic sda_line;
  int n_errors = 0;
  int n_checks = 0;
  int n_srst = 0;
  int cycles = 0;
  // Quiet gap after the reset codes, scaled far down from the real settle time
  localparam int SRST_SETTLE = 500;
  logic [6:0] addr_tab [4] = '{7'h68, 7'h69, 7'h58, 7'h59};

  // Pull-up: the line is low whenever either party pulls it
  assign sda_line = mst_sda & ~(sda_oe_o & ~sda_o);

  gic_cmd_port dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl_i(scl_line), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sel_i(sel_i), .addr_sel_i(addr_sel_i), .rate_i(rate_i),
    .temp_i(temp_i), .self_test_fail_flag_i(self_test_fail_flag_i), .soft_rst_o(soft_rst_o), .cmd_o(cmd_o));

  gic_bus_master_model m (.clk_sys_i(clk_sys_i), .sda_i(sda_line), .scl_o(scl_line), .sda_o(mst_sda));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (soft_rst_o === 1'b1) begin
      n_srst++;
    end
    if (cycles == 40000) begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic do_reset(input logic [1:0] s);
    rst_n_i <= 1'b0;
    addr_sel_i <= s;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask : do_reset

  // Leaves the frame open so a repeated start or a stop may follow
  task automatic send_cmd(input logic [6:0] a, input logic [7:0] c, input logic exp_nack);
    logic ack;
    m.start();
    m.wr_byte({a, 1'b0}, ack);
    chk_bit(ack, exp_nack, "address ack");
    if (!exp_nack) begin
      m.wr_byte(c, ack);
      chk_bit(ack, 1'b0, "command ack");
    end
  endtask : send_cmd

  task automatic get_resp(input int n, output logic [15:0] v);
    logic ack;
    logic [7:0] b;
    m.start();
    m.wr_byte({7'h68, 1'b1}, ack);
    chk_bit(ack, 1'b0, "read address ack");
    m.rd_byte(n == 1, b);
    chk_bit(sda_o, 1'b0, "open drain level");
    v = {8'h00, b};
    if (n == 2) begin
      m.rd_byte(1'b1, b);
      v = {v[7:0], b};
    end
    m.stop();
  endtask : get_resp

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rate_temp();
    logic [15:0] v;
    rate_i <= 16'h9a5c;
    temp_i <= 11'h5a3;
    send_cmd(7'h68, 8'h25, 1'b0);
    get_resp(2, v);
    chk_val(v, 16'h9a5c, "rate");
    chk_val({8'h00, cmd_o}, 16'h0025, "command latched");
    // Sign bit of temperature set, upper bits must stay zero
    send_cmd(7'h68, 8'h26, 1'b0);
    get_resp(2, v);
    chk_val(v, 16'h05a3, "temperature");
  endtask : t_rate_temp

  task automatic t_self_test();
    logic [15:0] v;
    for (int f = 0; f < 2; f++) begin
      self_test_fail_flag_i <= f[0];
      send_cmd(7'h68, 8'h29, 1'b0);
      get_resp(1, v);
      // Low six bits carry no meaning, so they are masked
      chk_val(v & 16'h00c0, {8'h00, 1'b0, f[0], 6'h00}, "self test");
    end
  endtask : t_self_test

  task automatic t_nack_early();
    logic [15:0] v;
    rate_i <= 16'h7f01;
    send_cmd(7'h68, 8'h25, 1'b0);
    get_resp(1, v);
    chk_val(v, 16'h007f, "rate cut short");
    get_resp(2, v);
    chk_val(v, 16'h7f01, "rate after stop");
  endtask : t_nack_early

  task automatic t_refused();
    logic [15:0] v;
    logic ack;
    send_cmd(7'h69, 8'h29, 1'b1);
    m.stop();
    chk_val({8'h00, cmd_o}, 16'h0025, "foreign address ignored");
    send_cmd(7'h68, 8'h26, 1'b0);
    m.wr_byte(8'h29, ack);
    chk_bit(ack, 1'b1, "extra byte refused");
    m.stop();
    get_resp(2, v);
    chk_val(v, 16'h05a3, "extra byte not a command");
    sel_i <= 1'b0;
    send_cmd(7'h68, 8'h25, 1'b1);
    m.stop();
    sel_i <= 1'b1;
    chk_val({8'h00, cmd_o}, 16'h0026, "select low ignored");
  endtask : t_refused

  // The long settle after the reset codes is only a short gap; the block keeps no timer for it
  task automatic t_soft_reset();
    logic [15:0] v;
    logic [7:0] brk [6] = '{8'h35, 8'h36, 8'h37, 8'h25, 8'h38, 8'h39};
    int base;
    base = n_srst;
    foreach (brk[i]) begin
      send_cmd(7'h68, brk[i], 1'b0);
      m.stop();
    end
    chk_val(16'(n_srst - base), 16'h0000, "broken sequence");
    for (logic [7:0] c = 8'h35; c <= 8'h39; c++) begin
      chk_val(16'(n_srst - base), 16'h0000, "early reset");
      send_cmd(7'h68, c, 1'b0);
      m.stop();
    end
    repeat (SRST_SETTLE) @(posedge clk_sys_i);
    chk_val(16'(n_srst - base), 16'h0001, "one reset pulse");
    chk_val({8'h00, cmd_o}, 16'h0000, "command cleared");
    get_resp(1, v);
    chk_val(v, 16'h00ff, "no response data");
  endtask : t_soft_reset

  task automatic t_addr_alt();
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      for (int j = 0; j < 4; j++) begin
        send_cmd(addr_tab[j], 8'h29, j != s);
        m.stop();
      end
    end
    do_reset(2'h0);
  endtask : t_addr_alt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    sel_i = 1'b1;
    addr_sel_i = 2'h0;
    rate_i = 16'h0000;
    temp_i = 11'h000;
    self_test_fail_flag_i = 1'b0;
    @(posedge clk_sys_i);
    do_reset(2'h0);
    t_rate_temp();
    t_self_test();
    t_nack_early();
    t_refused();
    t_soft_reset();
    t_addr_alt();
    final_report();
  end

endmodule : tb_top
